// ---- ldr_lut16.sv ----
// Configuration constants shared by the cell and its function generators,
// followed by one sixteen-entry function generator table.
// Assumes a single clock and a writer that keeps address and data steady
// around the edge on which the table is written.

// ============================================================
// Shared constants
// ============================================================
package ldr_pkg;

   // Register byte addresses on the bus.
   localparam logic [3:0]  LDR_CFG_OFS      = 4'h0;
   localparam logic [3:0]  LDR_STAT_OFS     = 4'h4;

   // Configuration field positions.
   localparam int          LDR_F_RAM_BIT    = 0;
   localparam int          LDR_G_RAM_BIT    = 1;
   localparam int          LDR_ARR_LSB      = 2;
   localparam int          LDR_LEVEL_BIT    = 4;
   localparam int          LDR_WFALL_BIT    = 5;
   localparam int          LDR_XH_BIT       = 6;
   localparam int          LDR_YH_BIT       = 7;
   localparam int          LDR_XQ_LSB       = 8;
   localparam int          LDR_YQ_LSB       = 10;
   localparam int          LDR_HTAB_LSB     = 16;

   // Writable bits of the configuration word and its value after reset.
   localparam logic [31:0] LDR_CFG_MASK     = 32'h00FF0FFF;
   localparam logic [31:0] LDR_CFG_RST      = 32'h00000000;

   // Table sizes.
   localparam int          LDR_DEPTH        = 16;
   localparam int          LDR_AW           = 4;
   localparam logic [15:0] LDR_INIT_ZERO    = 16'h0000;

   // Memory arrangement of the two generators.
   typedef enum logic [1:0] {
      LDR_ARR_SPLIT,
      LDR_ARR_WIDE32,
      LDR_ARR_DUAL,
      LDR_ARR_SPARE
   } ldr_arr_t;

   // Flip-flop data sources.
   typedef enum logic [1:0] {
      LDR_Q_FGEN,
      LDR_Q_GGEN,
      LDR_Q_HGEN,
      LDR_Q_DIRECT
   } ldr_qsrc_t;

endpackage

// ============================================================
// One function generator table
// ============================================================
module ldr_lut16
   import ldr_pkg::*;
#(
   parameter logic [LDR_DEPTH-1:0] INIT = LDR_INIT_ZERO
) (
   // Clock.
   input  wire logic              i_clk,
   // Write port.
   input  wire logic              i_we,
   input  wire logic [LDR_AW-1:0] i_waddr,
   input  wire logic              i_wdata,
   // Read port.
   input  wire logic [LDR_AW-1:0] i_raddr,
   output logic                   o_rdata
);

   // Contents load from the parameter and ignore the cell reset.
   logic [LDR_DEPTH-1:0] table_r = INIT;

   // The write pulse is the clock edge gated by the sampled enable.
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         table_r[i_waddr] <= i_wdata;
      end
   end

   // Reading is pure selection, so a write shows at once.
   assign o_rdata = table_r[i_raddr];

endmodule

// ---- ldr_cell.sv ----
// Logic cell whose two four-input function generators double as small
// read/write memories, plus a three-input generator and two flip-flops.
// Assumes user logic on i_clk drives the generator inputs and control
// lines, and software sets the cell up over an Avalon-MM slave port.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.

// ============================================================
// Cell top
// ============================================================
module ldr_cell
   import ldr_pkg::*;
#(
   parameter logic [LDR_DEPTH-1:0] INIT_FIRST  = LDR_INIT_ZERO,
   parameter logic [LDR_DEPTH-1:0] INIT_SECOND = LDR_INIT_ZERO
) (
   // Clock and reset.
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Avalon-MM register slave.
   input  wire logic [3:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic [31:0]            o_avs_readdata,
   output logic                   o_avs_waitrequest,
   // Generator inputs; the second set is the secondary read address except in the wide arrangement, which reads both tables at the first set.
   input  wire logic [LDR_AW-1:0] i_first_generator_inputs,
   input  wire logic [LDR_AW-1:0] i_second_generator_inputs,
   // Control lines: write data first, write data second, write enable.
   input  wire logic              i_direct_input_line,
   input  wire logic              i_third_generator_input_one,
   input  wire logic              i_set_reset_input_line,
   // Cell outputs.
   output logic                   o_x,
   output logic                   o_y,
   output logic                   o_xq,
   output logic                   o_yq,
   output logic                   o_primary_read_out,
   output logic                   o_secondary_read_out
);

   // ============================================================
   // Register slave
   // ============================================================
   logic [31:0] cfg_r;
   logic [31:0] readdata_r;
   logic        ack_r;
   logic        req;
   logic        hit_cfg;
   logic        hit_stat;
   logic [31:0] be_mask;
   logic [31:0] status;

   assign req      = i_avs_read | i_avs_write;
   assign hit_cfg  = (i_avs_address == LDR_CFG_OFS);
   assign hit_stat = (i_avs_address == LDR_STAT_OFS);
   assign be_mask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

   // Every access takes exactly one wait cycle, which gives read data a
   // register stage without any look-ahead decode.
   assign o_avs_waitrequest = req & ~ack_r;
   assign o_avs_readdata    = readdata_r;

   // The acknowledge toggles high for the cycle that ends each access.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read data are captured in the wait cycle; unmapped reads give zero.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         readdata_r <= 32'h00000000;
      end else if (i_avs_read && !ack_r) begin
         if (hit_cfg) begin
            readdata_r <= cfg_r;
         end else if (hit_stat) begin
            readdata_r <= status;
         end else begin
            readdata_r <= 32'h00000000;
         end
      end
   end

   // Writes land on the edge that ends the access; unmapped ones vanish.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_r <= LDR_CFG_RST;
      end else if (i_avs_write && ack_r && hit_cfg) begin
         cfg_r <= (cfg_r & ~(be_mask & LDR_CFG_MASK)) |
                  (i_avs_writedata & be_mask & LDR_CFG_MASK);
      end
   end

   // ============================================================
   // Configuration decode
   // ============================================================
   ldr_arr_t   arr;
   ldr_qsrc_t  xq_src;
   ldr_qsrc_t  yq_src;
   logic       f_ram;
   logic       g_ram;
   logic       level_mode;
   logic       wfall;
   logic [7:0] h_table;

   assign arr     = ldr_arr_t'(cfg_r[LDR_ARR_LSB +: 2]);
   assign xq_src  = ldr_qsrc_t'(cfg_r[LDR_XQ_LSB +: 2]);
   assign yq_src  = ldr_qsrc_t'(cfg_r[LDR_YQ_LSB +: 2]);
   assign h_table = cfg_r[LDR_HTAB_LSB +: 8];

   // Wide and dual arrangements need both tables, so they force memory on;
   // otherwise each generator chooses on its own.
   assign f_ram = cfg_r[LDR_F_RAM_BIT] | (arr == LDR_ARR_WIDE32) |
                  (arr == LDR_ARR_DUAL);
   assign g_ram = cfg_r[LDR_G_RAM_BIT] | (arr == LDR_ARR_WIDE32) |
                  (arr == LDR_ARR_DUAL);

   // A single timing bit and a single polarity bit serve the whole cell,
   // so the two tables can never disagree. Dual port is edge-only.
   assign level_mode = cfg_r[LDR_LEVEL_BIT] & (arr != LDR_ARR_DUAL);
   assign wfall      = cfg_r[LDR_WFALL_BIT] & ~level_mode;

   // ============================================================
   // Write sampling
   // ============================================================
   // The control lines are repurposed as data and enable.
   logic              wd_first;
   logic              wd_second;
   logic              wen;
   logic [LDR_AW-1:0] fall_addr_f_r;
   logic [LDR_AW-1:0] fall_addr_g_r;
   logic              fall_d0_r;
   logic              fall_d1_r;
   logic              fall_we_r;

   assign wd_first  = i_direct_input_line;
   assign wd_second = i_third_generator_input_one;
   assign wen       = i_set_reset_input_line;

   // For a falling write edge the inputs are sampled on that edge and the
   // table is written from the sample, so changes in the following half
   // period cannot reach the array.
   always_ff @(negedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fall_addr_f_r <= 4'h0;
         fall_addr_g_r <= 4'h0;
         fall_d0_r     <= 1'b0;
         fall_d1_r     <= 1'b0;
         fall_we_r     <= 1'b0;
      end else begin
         fall_addr_f_r <= i_first_generator_inputs;
         fall_addr_g_r <= i_second_generator_inputs;
         fall_d0_r     <= wd_first;
         fall_d1_r     <= wd_second;
         fall_we_r     <= wen;
      end
   end

   // Sampled view chosen by the write polarity. A level-mode strobe is
   // seen on each rising edge while high; it is kept only for old designs.
   logic [LDR_AW-1:0] s_addr_f;
   logic [LDR_AW-1:0] s_addr_g;
   logic              s_d0;
   logic              s_d1;
   logic              s_we;

   assign s_addr_f = wfall ? fall_addr_f_r : i_first_generator_inputs;
   assign s_addr_g = wfall ? fall_addr_g_r : i_second_generator_inputs;
   assign s_d0     = wfall ? fall_d0_r : wd_first;
   assign s_d1     = wfall ? fall_d1_r : wd_second;
   assign s_we     = wfall ? fall_we_r : wen;

   // ============================================================
   // Per-generator write steering
   // ============================================================
   logic [1:0]        gen_we;
   logic [1:0]        gen_wdata;
   logic [LDR_AW-1:0] gen_waddr [2];
   logic [LDR_AW-1:0] gen_raddr [2];
   logic [1:0]        gen_out;

   always_comb begin
      gen_we[0]    = s_we & f_ram;
      gen_we[1]    = s_we & g_ram;
      gen_wdata[0] = s_d0;
      gen_wdata[1] = s_d1;
      gen_waddr[0] = s_addr_f;
      gen_waddr[1] = s_addr_g;
      gen_raddr[0] = i_first_generator_inputs;
      gen_raddr[1] = i_second_generator_inputs;
      case (arr)
         LDR_ARR_WIDE32: begin
            // Both tables share the first address; the second data line
            // picks the half and the first carries the data.
            gen_we[0]    = s_we & ~s_d1;
            gen_we[1]    = s_we & s_d1;
            gen_wdata[1] = s_d0;
            gen_waddr[1] = s_addr_f;
            gen_raddr[1] = i_first_generator_inputs;
         end
         LDR_ARR_DUAL: begin
            // One write address and datum feed both tables, so the second
            // table mirrors the first and reads at its own address.
            gen_wdata[1] = s_d0;
            gen_waddr[1] = s_addr_f;
         end
         default: begin
            // Two independent 16x1 tables, the 16x2 case.
            gen_we[0] = s_we & f_ram;
         end
      endcase
   end

   // The two tables are identical, so one loop builds both.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_gen
         ldr_lut16 #(
            .INIT    (gi == 0 ? INIT_FIRST : INIT_SECOND)
         ) u_lut (
            .i_clk   (i_clk),
            .i_we    (gen_we[gi]),
            .i_waddr (gen_waddr[gi]),
            .i_wdata (gen_wdata[gi]),
            .i_raddr (gen_raddr[gi]),
            .o_rdata (gen_out[gi])
         );
      end
   endgenerate

   // ============================================================
   // Read outputs and third generator
   // ============================================================
   logic       f_out;
   logic       g_out;
   logic       h_out;
   logic [2:0] h_idx;

   assign f_out = gen_out[0];
   assign g_out = gen_out[1];

   // Reads select by each generator's own inputs; only the wide one reads both
   // tables at the first address and adds a final pick by the fifth address bit.
   assign o_primary_read_out = (arr == LDR_ARR_WIDE32) ?
                               (wd_second ? g_out : f_out) : f_out;
   assign o_secondary_read_out = g_out;

   // The third generator keeps combining both outputs with the second
   // data line even when the tables hold memory.
   assign h_idx = {wd_second, g_out, f_out};
   assign h_out = h_table[h_idx];

   // Unregistered exits.
   assign o_x = cfg_r[LDR_XH_BIT] ? h_out : f_out;
   assign o_y = cfg_r[LDR_YH_BIT] ? h_out : g_out;

   // ============================================================
   // Cell flip-flops
   // ============================================================
   // Source select for one flip-flop.
   function automatic logic ldr_qsel(input ldr_qsrc_t src, input logic f,
                                     input logic g, input logic h,
                                     input logic d);
      logic r;
      case (src)
         LDR_Q_FGEN: r = f;
         LDR_Q_GGEN: r = g;
         LDR_Q_HGEN: r = h;
         default:    r = d;
      endcase
      return r;
   endfunction

   // The flops clear on reset, while the tables keep their contents.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_xq <= 1'b0;
         o_yq <= 1'b0;
      end else begin
         o_xq <= ldr_qsel(xq_src, f_out, g_out, h_out, wd_first);
         o_yq <= ldr_qsel(yq_src, f_out, g_out, h_out, wd_first);
      end
   end

   // Status view of the generator outputs and flops.
   assign status = {27'h0000000, o_yq, o_xq, h_out, g_out, f_out};

endmodule

// ---- ldr_cell_monitor.sv ----
// Checker for the logic cell: bus handshake and table read-back relations.
// Assumes it is bound into ldr_cell and sees only that module's ports.

// ==========
// Checker
// ==========
module ldr_cell_mon
   import ldr_pkg::*;
(
   // Clock and reset.
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   // Register bus.
   input wire logic [3:0]        i_avs_address,
   input wire logic              i_avs_read,
   input wire logic              i_avs_write,
   input wire logic [31:0]       i_avs_writedata,
   input wire logic [3:0]        i_avs_byteenable,
   input wire logic [31:0]       o_avs_readdata,
   input wire logic              o_avs_waitrequest,
   // Cell pins.
   input wire logic [LDR_AW-1:0] i_first_generator_inputs,
   input wire logic [LDR_AW-1:0] i_second_generator_inputs,
   input wire logic              i_direct_input_line,
   input wire logic              i_third_generator_input_one,
   input wire logic              i_set_reset_input_line,
   input wire logic              o_x,
   input wire logic              o_xq,
   input wire logic              o_primary_read_out,
   input wire logic              o_secondary_read_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [31:0]       cfg_r;
   logic [31:0]       cfg_nxt;
   // Short aliases keep the properties readable.
   wire logic [3:0]   fa   = i_first_generator_inputs;
   wire logic [3:0]   sa   = i_second_generator_inputs;
   wire logic         d0   = i_direct_input_line;
   wire logic         d1   = i_third_generator_input_one;
   wire logic         we   = i_set_reset_input_line;
   wire logic [1:0]   arr  = cfg_r[3:2];
   wire logic         rdok = i_avs_read && !o_avs_waitrequest;
   wire logic         fmem = cfg_r[0] || arr == 2'h1 || arr == 2'h2;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // Shadow of the configuration word, so mode-dependent checks can
   // qualify themselves without peeking inside the cell.
   always_comb begin
      cfg_nxt = cfg_r;
      if (i_avs_write && !o_avs_waitrequest &&
          i_avs_address == LDR_CFG_OFS) begin
         for (int b = 0; b < 4; b++) begin
            if (i_avs_byteenable[b]) begin
               cfg_nxt[8*b +: 8] = i_avs_writedata[8*b +: 8];
            end
         end
         cfg_nxt = cfg_nxt & LDR_CFG_MASK;
      end
   end

   // Shadow register, cleared with the cell.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_r <= LDR_CFG_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   a_wait_one: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_unmapped_zero: assert property (
      rdok && i_avs_address != LDR_CFG_OFS && i_avs_address != LDR_STAT_OFS
      |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_readback: assert property (
      rdok && i_avs_address == LDR_CFG_OFS |-> o_avs_readdata == cfg_r)
      else $error("config read-back mismatch");
   // The sampled reset keeps the release edge out: the flop still clears
   // on it, so it cannot hold the generator value one edge later.
   a_xq_from_f: assert property (
      i_rst_n && !cfg_r[6] && cfg_r[9:8] == 2'h0 |=> o_xq == $past(o_x))
      else $error("flop did not capture generator output");
   a_primary_write: assert property (
      fmem && we ##1 ($stable(fa) && $stable(cfg_r) &&
      (arr != 2'h1 || $stable(d1))) |-> o_primary_read_out == $past(d0))
      else $error("primary table write not seen");
   a_second_write: assert property (
      cfg_r[1] && arr[0] == arr[1] && we ##1 ($stable(sa) && $stable(cfg_r))
      |-> o_secondary_read_out == $past(d1))
      else $error("second table write not seen");
   a_dual_read: assert property (
      arr == 2'h2 && we ##1 ($stable(cfg_r) && sa == $past(fa))
      |-> o_secondary_read_out == $past(d0))
      else $error("dual port read mismatch");
   a_we_low_hold: assert property (
      !we ##1 ($stable(fa) && $stable(d1) && $stable(cfg_r))
      |-> $stable(o_primary_read_out))
      else $error("table changed without write enable");

   c_dual_write: cover property (arr == 2'h2 && we);
   c_wide_write: cover property (arr == 2'h1 && we);
   c_cfg_read: cover property (rdok && i_avs_address == LDR_CFG_OFS);
endmodule

bind ldr_cell ldr_cell_mon mon_u (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_first_generator_inputs(i_first_generator_inputs),
   .i_second_generator_inputs(i_second_generator_inputs),
   .i_direct_input_line(i_direct_input_line),
   .i_third_generator_input_one(i_third_generator_input_one),
   .i_set_reset_input_line(i_set_reset_input_line), .o_x(o_x),
   .o_xq(o_xq), .o_primary_read_out(o_primary_read_out),
   .o_secondary_read_out(o_secondary_read_out)
);

// ---- ldr_user_logic.sv ----
// Model of the user logic that drives the cell's address, data and
// write-enable pins. Assumes the bench calls drive once per clock.

// ==========
// User logic
// ==========
module ldr_user_logic
   import ldr_pkg::*;
(
   // Clock.
   input  wire logic         i_clk,
   // Pins driven into the cell.
   output logic [LDR_AW-1:0] o_first,
   output logic [LDR_AW-1:0] o_second,
   output logic              o_data_first,
   output logic              o_data_second,
   output logic              o_write_enable
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet pins at time zero so no write happens before the first call.
   initial begin
      o_first        = '0;
      o_second       = '0;
      o_data_first   = 1'b0;
      o_data_second  = 1'b0;
      o_write_enable = 1'b0;
   end

   // Holds every pin a whole cycle, so a falling-edge capture sees the
   // same values as a rising-edge one would.
   task automatic drive(input logic [3:0] a, input logic [3:0] b,
                        input logic d0, input logic d1, input logic we);
      @(posedge i_clk);
      o_first        <= a;
      o_second       <= b;
      o_data_first   <= d0;
      o_data_second  <= d1;
      o_write_enable <= we;
   endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the logic cell: bus access plus random table
// traffic in the split, wide and dual arrangements, checked against a behavioural model.
// Assumes the checker is bound in and the user-logic model drives pins.

// ==========
// Bench
// ==========
module tb_top
   import ldr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [15:0] INIT_F = 16'hA5C3;
   localparam logic [15:0] INIT_G = 16'h3C96;
   // Modes: split, split falling, legacy level on one table, wide,
   // dual with the ignored level bit, logic only.
   localparam logic [31:0] MODES [6] = '{32'h003, 32'h763, 32'h011,
                                         32'hF04, 32'h018, 32'hBC0};

   logic        i_clk;
   logic        i_rst_n;
   logic [3:0]  adr;
   logic        rd_q;
   logic        wr_q;
   logic [31:0] wdat;
   logic [3:0]  be;
   wire  [31:0] rdat;
   wire         wait_q;
   wire  [3:0]  fa;
   wire  [3:0]  sa;
   wire         d0_w;
   wire         d1_w;
   wire         we_w;
   wire         x_w;
   wire         y_w;
   wire         xq_w;
   wire         yq_w;
   wire         po_w;
   wire         so_w;
   int          n_errors;
   int          samples_checked;
   int          f [16];
   int          g [16];
   logic [31:0] cfg;

   ldr_cell #(.INIT_FIRST(INIT_F), .INIT_SECOND(INIT_G)) dut_u (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
      .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
      .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wait_q), .i_first_generator_inputs(fa),
      .i_second_generator_inputs(sa), .i_direct_input_line(d0_w),
      .i_third_generator_input_one(d1_w), .i_set_reset_input_line(we_w),
      .o_x(x_w), .o_y(y_w), .o_xq(xq_w), .o_yq(yq_w),
      .o_primary_read_out(po_w), .o_secondary_read_out(so_w));

   ldr_user_logic p_u (.i_clk(i_clk), .o_first(fa), .o_second(sa),
      .o_data_first(d0_w), .o_data_second(d1_w), .o_write_enable(we_w));

   // Free-running clock: the write clock is never parked after an edge.
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // Reports the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus access; the request stands until waitrequest is seen low.
   // A slave that never answers is left to the watchdog.
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] e,
                      output logic [31:0] r);
      @(posedge i_clk);
      rd_q <= !w;
      wr_q <= w;
      adr  <= a;
      wdat <= d;
      be   <= e;
      do begin
         @(posedge i_clk);
      end while (wait_q !== 1'b0);
      r = rdat;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
   endtask

   // A hang ends the run with a failure.
   initial begin
      #(25 * 5000);
      n_errors++;
      complete_run();
   end

   initial begin
      logic [31:0] r;
      logic [3:0]  a;
      logic [3:0]  b;
      logic        d0;
      logic        d1;
      logic        we;
      logic        wide;
      int          fx;
      int          gx;
      int          hx;
      logic [3:0]  pq;
      void'($urandom(82540));
      {rd_q, wr_q, adr, wdat, be} = '0;
      i_rst_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         f[i] = INIT_F[i];
         g[i] = INIT_G[i];
      end
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // Register reset value, unmapped access, mask and byte lanes.
      bus(0, LDR_CFG_OFS, 0, 0, r);
      chk(r, LDR_CFG_RST);
      bus(1, 4'hC, 32'hFFFFFFFF, 4'hF, r);
      bus(0, 4'hC, 0, 0, r);
      chk(r, 32'h0);
      bus(1, LDR_CFG_OFS, 32'hFFFFFFFF, 4'hF, r);
      bus(1, LDR_CFG_OFS, 32'h0, 4'h1, r);
      bus(0, LDR_CFG_OFS, 0, 0, r);
      chk(r, LDR_CFG_MASK & 32'hFFFFFF00);
      bus(0, LDR_STAT_OFS, 0, 0, r);
      chk(r & 32'hFFFFFFE0, 32'h0);
      for (int m = 0; m < 6; m++) begin
         // A mid-run reset must leave the table contents alone.
         if (m == 2) begin
            i_rst_n <= 1'b0;
            repeat (2) @(posedge i_clk);
            i_rst_n <= 1'b1;
         end
         cfg = (MODES[m] | ($urandom & 32'h00FF0000)) & LDR_CFG_MASK;
         bus(1, LDR_CFG_OFS, cfg, 4'hF, r);
         wide = (cfg[3:2] == 2'h1);
         for (int i = 0; i < 60; i++) begin
            a  = 4'($urandom) & (m[0] ? 4'hF : 4'h3);
            b  = wide ? a : 4'($urandom) & (m[0] ? 4'hF : 4'h3);
            d0 = 1'($urandom);
            d1 = 1'($urandom);
            we = 1'($urandom);
            p_u.drive(a, b, d0, d1, we);
            @(negedge i_clk);
            fx = f[a];
            gx = g[b];
            chk(po_w, wide ? (d1 ? g[a] : f[a]) : fx);
            if (!wide)
               chk(so_w, gx);
            hx = cfg[16 + 4 * d1 + 2 * gx + fx];
            chk(x_w, cfg[6] ? hx : fx);
            chk(y_w, cfg[7] ? hx : gx);
            // Flops show the source picked at the previous edge.
            if (i > 0) begin
               chk(xq_w, pq[cfg[9:8]]);
               chk(yq_w, pq[cfg[11:10]]);
            end
            pq = {d0, hx[0], gx[0], fx[0]};
            if (we && wide) begin
               if (d1)
                  g[a] = d0;
               else
                  f[a] = d0;
            end else if (we && cfg[3:2] == 2'h2) begin
               f[a] = d0;
               g[a] = d0;
            end else if (we) begin
               if (cfg[0])
                  f[a] = d0;
               if (cfg[1])
                  g[b] = d1;
            end
         end
         p_u.drive(4'h0, 4'h0, 1'b0, 1'b0, 1'b0);
      end
      complete_run();
   end
endmodule
